// ### logic/icfm_regs.vh
// Register indices, field positions, reset values and timing counts of the clock monitor.
`ifndef ICFM_REGS_VH
`define ICFM_REGS_VH
`define ICFM_CLK_NS 50
`define ICFM_TICK_NS 1000
`define ICFM_TICK_CYC (`ICFM_TICK_NS / `ICFM_CLK_NS)
`define ICFM_STBL0_US 40
`define ICFM_STBL1_US 80
`define ICFM_STBL2_US 11'd320
`define ICFM_STBL3_US 11'd1280
`define ICFM_STBL0_TICKS (`ICFM_STBL0_US * 1000 / `ICFM_TICK_NS)
`define ICFM_STBL1_TICKS (`ICFM_STBL1_US * 1000 / `ICFM_TICK_NS)
`define ICFM_IDX_CTL1 8'h5b
`define ICFM_IDX_CTL2 8'h5c
`define ICFM_IDX_LOW 8'h5d
`define ICFM_IDX_HIGH 8'h5e
`define ICFM_IDX_FREQ 8'h5f
`define ICFM_IDX_STAT 8'h70
`define ICFM_IDX_MASK 8'h71
`define ICFM_IDX_LIVE 8'h72
`define ICFM_B_SWAP 6
`define ICFM_B_PLLRST 5
`define ICFM_B_SRCSEL 4
`define ICFM_B_SWAP_DIS 7
`define ICFM_B_FORCE_RDY 6
`define ICFM_B_FORCE_CLK 5
`define ICFM_B_RSTMODE 6
`define ICFM_RST_CTL1 8'h20
`define ICFM_RST_CTL2 8'h02
`define ICFM_RST_LOW 8'h06
`define ICFM_RST_HIGH 8'h2c
`define ICFM_EV_VALID_UP 0
`define ICFM_EV_VALID_DN 1
`define ICFM_EV_FREQ 2
`define ICFM_SY_RAW 0
`define ICFM_SY_PLL 1
`define ICFM_SY_LINK 2
`define ICFM_SY_5V 3
`define ICFM_SY_SWAP 4
`define ICFM_SY_MODE 5
`define ICFM_SY_N 6
`endif

// ### logic/icfm_freq_meter.v
// Edge counter that measures a synchronised clock level over one microsecond windows.
`timescale 1ns/1ps
module icfm_freq_meter (
  input wire clk, // Block clock.
  input wire reset_n, // Asynchronous reset, active low.
  input wire tick, // One-cycle pulse that closes each window.
  input wire clk_level, // Measured clock, already synchronised.
  output reg [7:0] count_q, // Rising edges seen in the last window, in MHz.
  output reg done_q // One-cycle pulse when count_q is fresh.
);
  reg lvl_q;
  reg [7:0] cnt_q;
  wire rise;
  wire [7:0] cnt_inc;

  // One rising edge per microsecond window equals one MHz.
  assign rise = clk_level & ~lvl_q;
  // Saturate so a clock far too fast cannot wrap to a small reading.
  assign cnt_inc = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;

  // Count edges and hand the total over at the end of each window.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvl_q <= 1'b0;
      cnt_q <= 8'h00;
      count_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      lvl_q <= clk_level;
      done_q <= tick;
      if (tick) begin
        count_q <= rise ? cnt_inc : cnt_q;
        cnt_q <= 8'h00;
      end else if (rise) begin
        cnt_q <= cnt_inc;
      end
    end
  end
endmodule

// ### logic/icfm_top.v
// Input clock frequency monitor with clock-valid, link-ready, reset policy and swap control.
`timescale 1ns/1ps
`include "icfm_regs.vh"
module icfm_top #(
  parameter [10:0] STBL2_US = `ICFM_STBL2_US, // Stability time of code 2, in microseconds.
  parameter [10:0] STBL3_US = `ICFM_STBL3_US // Stability time of code 3, in microseconds.
) (
  input wire CLK, // Block clock, 20 MHz.
  input wire RESET_N, // Asynchronous reset, active low.
  input wire CYC_I, // Wishbone cycle.
  input wire STB_I, // Wishbone strobe.
  input wire WE_I, // Wishbone write enable.
  input wire [9:0] ADR_I, // Wishbone byte address.
  input wire [3:0] SEL_I, // Wishbone byte selects.
  input wire [31:0] DAT_I, // Wishbone write data.
  output wire [31:0] DAT_O, // Wishbone read data.
  output wire ACK_O, // Wishbone acknowledge.
  input wire IN_CLK_RAW, // Video input clock ahead of the PLL.
  input wire IN_CLK_PLL, // Video input PLL output clock.
  input wire LINK_DETECT, // Back-channel link detected, level.
  input wire SUPPLY_5V_DETECT, // Source +5 V present, level.
  input wire SWAP_DETECTED, // Auto-detected dual-link swap state, level.
  input wire LINK_MODE, // Link mode level; any change is a mode change.
  output wire CLOCK_VALID, // Input clock judged valid.
  output wire LINK_READY, // Link ready indication.
  output wire SWAP_ACTIVE, // Current dual-link swap state.
  output wire PHY_RESET, // One-cycle reset pulse to the receiver PHY.
  output wire PLL_RESET, // One-cycle reset pulse to the link transmit PLL.
  output wire IRQ // Level interrupt.
);
  // Timing counts are worked out as integers, then cut to the counter widths on purpose.
  localparam integer TICK_LAST_I = `ICFM_TICK_CYC - 1;
  localparam integer STBL0_I = `ICFM_STBL0_TICKS;
  localparam integer STBL1_I = `ICFM_STBL1_TICKS;
  localparam [4:0] TICK_LAST = TICK_LAST_I[4:0];
  localparam [10:0] STBL0_T = STBL0_I[10:0];
  localparam [10:0] STBL1_T = STBL1_I[10:0];

  reg [`ICFM_SY_N-1:0] sy1_q;
  reg [`ICFM_SY_N-1:0] sy2_q;
  reg [7:0] ctl1_q;
  reg [7:0] ctl2_q;
  reg [7:0] low_q;
  reg [7:0] high_q;
  reg [2:0] stat_q;
  reg [2:0] mask_q;
  reg [2:0] stat_d;
  reg [7:0] freq_q;
  reg [10:0] stbl_q;
  reg [4:0] div_q;
  reg tick_q;
  reg mode_q;
  reg valid_q;
  reg ready_q;
  reg phy_rst_q;
  reg pll_rst_q;
  reg irq_q;
  reg ack_q;
  reg [31:0] dat_q;
  reg [7:0] rdata;
  reg [10:0] stbl_thr;
  reg [7:0] diff;
  reg freq_chg;
  wire [`ICFM_SY_N-1:0] pins;
  wire meas_lvl;
  wire [7:0] meas;
  wire meas_done;
  wire req;
  wire [7:0] idx;
  wire wr;
  wire in_range;
  wire stable;
  wire valid_d;
  wire mode_chg;

  assign pins = {LINK_MODE, SWAP_DETECTED, SUPPLY_5V_DETECT, LINK_DETECT, IN_CLK_PLL, IN_CLK_RAW};

  // Two-flop synchronisers; only the second stage feeds any logic.
  genvar g;
  generate
    for (g = 0; g < `ICFM_SY_N; g = g + 1) begin : sync
      always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          sy1_q[g] <= 1'b0;
          sy2_q[g] <= 1'b0;
        end else begin
          sy1_q[g] <= pins[g];
          sy2_q[g] <= sy1_q[g];
        end
      end
    end
  endgenerate

  // Source select picks the clock that the meter sees.
  assign meas_lvl = ctl1_q[`ICFM_B_SRCSEL] ? sy2_q[`ICFM_SY_PLL]
    : sy2_q[`ICFM_SY_RAW];

  // Microsecond tick divider; only the meter window and the stability count work on this enable.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == TICK_LAST);
      div_q <= (div_q == TICK_LAST) ? 5'h00 : div_q + 5'h01;
    end
  end

  icfm_freq_meter meter (
    .clk(CLK),
    .reset_n(RESET_N),
    .tick(tick_q),
    .clk_level(meas_lvl),
    .count_q(meas),
    .done_q(meas_done)
  );

  // Hysteresis filter; a reading of zero always goes through so loss of signal shows at once.
  always @* begin
    diff = (meas > freq_q) ? meas - freq_q : freq_q - meas;
    freq_chg = 1'b0;
    if (meas_done) begin
      if (meas == 8'h00 || freq_q == 8'h00) begin
        freq_chg = (meas != freq_q);
      end else begin
        freq_chg = (diff > {5'h00, ctl2_q[2:0]});
      end
    end
  end

  // Stability time chosen by the two-bit select.
  always @* begin
    case (ctl2_q[4:3])
      2'b00: stbl_thr = STBL0_T;
      2'b01: stbl_thr = STBL1_T;
      2'b10: stbl_thr = STBL2_US;
      default: stbl_thr = STBL3_US;
    endcase
  end

  // Stored frequency and the time it has held inside the band.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      freq_q <= 8'h00;
      stbl_q <= 11'h000;
    end else begin
      if (freq_chg) begin
        freq_q <= meas;
        stbl_q <= 11'h000;
      end else if (tick_q && stbl_q != 11'h7ff) begin
        stbl_q <= stbl_q + 11'h001;
      end
    end
  end

  assign stable = (stbl_q >= stbl_thr);
  // Limits include their own value; zero means no signal and never passes.
  assign in_range = (freq_q != 8'h00)
    && (freq_q >= {2'b00, low_q[5:0]})
    && (freq_q <= {1'b0, high_q[6:0]});
  // The force bit bypasses both checks; otherwise validity falls one cycle after a check fails.
  assign valid_d = ctl2_q[`ICFM_B_FORCE_CLK] | (in_range & stable);
  assign mode_chg = (sy2_q[`ICFM_SY_MODE] != mode_q);

  // Output flags and reset pulses.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      valid_q <= 1'b0;
      ready_q <= 1'b0;
      mode_q <= 1'b0;
      phy_rst_q <= 1'b0;
      pll_rst_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      ready_q <= ctl2_q[`ICFM_B_FORCE_RDY] | sy2_q[`ICFM_SY_LINK];
      mode_q <= sy2_q[`ICFM_SY_MODE];
      // The PHY reset is held off only when mode 1 is chosen and the supply is present.
      phy_rst_q <= (freq_chg | mode_chg)
        & ~(low_q[`ICFM_B_RSTMODE] & sy2_q[`ICFM_SY_5V]);
      pll_rst_q <= freq_chg & ctl1_q[`ICFM_B_PLLRST];
    end
  end

  // Wishbone decode: one word per register, answered one cycle after the request.
  assign req = CYC_I & STB_I & ~ack_q;
  assign idx = ADR_I[9:2];
  assign wr = req & WE_I & SEL_I[0];

  // Read mux; unmapped indices read zero and reserved bits read zero.
  always @* begin
    case (idx)
      `ICFM_IDX_CTL1: rdata = {1'b0, ctl1_q[6:4], 4'h0};
      `ICFM_IDX_CTL2: rdata = ctl2_q;
      `ICFM_IDX_LOW: rdata = {1'b0, low_q[6:0]};
      `ICFM_IDX_HIGH: rdata = {1'b0, high_q[6:0]};
      `ICFM_IDX_FREQ: rdata = freq_q;
      `ICFM_IDX_STAT: rdata = {5'h00, stat_q};
      `ICFM_IDX_MASK: rdata = {5'h00, mask_q};
      `ICFM_IDX_LIVE: rdata = {5'h00, SWAP_ACTIVE, ready_q, valid_q};
      default: rdata = 8'h00;
    endcase
  end

  // Bus handshake and read data; ack drops the cycle after it was given.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= {24'h000000, rdata};
      end
    end
  end

  // Software-written control registers; the frequency register ignores writes.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctl2_q <= `ICFM_RST_CTL2;
      low_q <= `ICFM_RST_LOW;
      high_q <= `ICFM_RST_HIGH;
      mask_q <= 3'h0;
    end else if (wr) begin
      case (idx)
        `ICFM_IDX_CTL2: ctl2_q <= DAT_I[7:0];
        `ICFM_IDX_LOW: low_q <= {1'b0, DAT_I[6:0]};
        `ICFM_IDX_HIGH: high_q <= {1'b0, DAT_I[6:0]};
        `ICFM_IDX_MASK: mask_q <= DAT_I[2:0];
        default: mask_q <= mask_q;
      endcase
    end
  end

  // Control one: the swap bit follows the detector unless correction is off.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctl1_q <= `ICFM_RST_CTL1;
    end else begin
      if (wr && idx == `ICFM_IDX_CTL1) begin
        ctl1_q[`ICFM_B_PLLRST] <= DAT_I[`ICFM_B_PLLRST];
        ctl1_q[`ICFM_B_SRCSEL] <= DAT_I[`ICFM_B_SRCSEL];
      end
      if (!ctl2_q[`ICFM_B_SWAP_DIS]) begin
        ctl1_q[`ICFM_B_SWAP] <= sy2_q[`ICFM_SY_SWAP];
      end else if (wr && idx == `ICFM_IDX_CTL1) begin
        ctl1_q[`ICFM_B_SWAP] <= DAT_I[`ICFM_B_SWAP];
      end
    end
  end

  // Sticky events, cleared by writing one; a new event in the same cycle wins.
  always @* begin
    stat_d = stat_q;
    if (wr && idx == `ICFM_IDX_STAT) begin
      stat_d = stat_q & ~DAT_I[2:0];
    end
    if (valid_d && !valid_q) begin
      stat_d[`ICFM_EV_VALID_UP] = 1'b1;
    end
    if (!valid_d && valid_q) begin
      stat_d[`ICFM_EV_VALID_DN] = 1'b1;
    end
    if (freq_chg) begin
      stat_d[`ICFM_EV_FREQ] = 1'b1;
    end
  end

  // Status and interrupt registers; the interrupt is a level, not a pulse.
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stat_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
    end
  end

  // Every output comes straight from a flip-flop, so no glitch reaches the pins.
  assign DAT_O = dat_q;
  assign ACK_O = ack_q;
  assign CLOCK_VALID = valid_q;
  assign LINK_READY = ready_q;
  assign SWAP_ACTIVE = ctl1_q[`ICFM_B_SWAP];
  assign PHY_RESET = phy_rst_q;
  assign PLL_RESET = pll_rst_q;
  assign IRQ = irq_q;
endmodule

// ### tb/icfm_video_src.sv
// Behavioural video source that makes the raw and PLL input clocks.
`timescale 1ns/1ps
module icfm_video_src (
  input wire raw_en, // Run the raw clock.
  input wire pll_en, // Run the PLL clock.
  output reg raw, // Raw input clock, 400 ns period.
  output reg pll // PLL output clock, 400 ns period.
);
  // A stopped clock rests low, so the meter sees no edges at all.
  initial raw = 1'b0;
  initial pll = 1'b0;
  always #200 begin
    raw = raw_en ? ~raw : 1'b0;
    pll = pll_en ? ~pll : 1'b0;
  end
endmodule

// ### tb/icfm_props.sv
// Checker of the monitor's bus answers, reset pulses and level outputs.
`timescale 1ns/1ps
module icfm_props #(
  parameter [10:0] STBL2_US = 11'd320, // Stability time of code 2.
  parameter [10:0] STBL3_US = 11'd1280 // Stability time of code 3.
) (
  input wire CLK, // Block clock.
  input wire RESET_N, // Asynchronous reset, active low.
  input wire CYC_I, // Bus cycle.
  input wire STB_I, // Bus strobe.
  input wire [31:0] DAT_O, // Read data.
  input wire ACK_O, // Acknowledge.
  input wire LINK_DETECT, // Back-channel detect.
  input wire LINK_READY, // Link ready.
  input wire SWAP_DETECTED, // Detected swap state.
  input wire SWAP_ACTIVE, // Current swap state.
  input wire PHY_RESET, // Receiver reset pulse.
  input wire PLL_RESET // Transmit PLL reset pulse.
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence req_taken;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence link_held;
    LINK_DETECT [*4];
  endsequence
  // Five quiet cycles leave room for the two-flop synchroniser and its register.
  sequence swap_quiet;
    (!CYC_I && $stable(SWAP_DETECTED)) [*5];
  endsequence
  chk_ack_answer: assert property (req_taken |=> ACK_O)
    else $error("request not answered next cycle");
  chk_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("acknowledge longer than one cycle");
  chk_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("acknowledge without request");
  chk_read_width: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_phy_pulse: assert property (PHY_RESET |=> !PHY_RESET)
    else $error("receiver reset longer than one cycle");
  chk_pll_pulse: assert property (PLL_RESET |=> !PLL_RESET)
    else $error("PLL reset longer than one cycle");
  chk_link_ready: assert property (link_held |=> LINK_READY)
    else $error("link ready missing while detected");
  chk_swap_hold: assert property (swap_quiet |=> $stable(SWAP_ACTIVE))
    else $error("swap state moved without cause");
endmodule

// ### tb/icfm_top_tb.sv
// Self-checking bench of the input clock frequency monitor.
`timescale 1ns/1ps
module icfm_top_tb;
  reg clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg link = 1'b0, s5v = 1'b0, swap = 1'b0, mode = 1'b0, raw_en = 1'b0, pll_en = 1'b0;
  reg [9:0] adr = 10'h000;
  reg [3:0] sel = 4'h0;
  reg [31:0] wdat = 32'h00000000;
  reg [7:0] v, hc, pc, phy_cnt = 8'h00, pll_cnt = 8'h00;
  wire [31:0] rdat;
  wire ack, raw, pll, valid, ready, sw_act, phy, pllr, irq;
  integer errors = 0, tests_run = 0, i;

  // Stability codes 2 and 3 are shortened to keep the run brief.
  icfm_top #(.STBL2_US(11'd8), .STBL3_US(11'd16)) u_icfm_top (.CLK(clk), .RESET_N(rst_n),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
    .DAT_O(rdat), .ACK_O(ack), .IN_CLK_RAW(raw), .IN_CLK_PLL(pll), .LINK_DETECT(link),
    .SUPPLY_5V_DETECT(s5v), .SWAP_DETECTED(swap), .LINK_MODE(mode), .CLOCK_VALID(valid),
    .LINK_READY(ready), .SWAP_ACTIVE(sw_act), .PHY_RESET(phy), .PLL_RESET(pllr), .IRQ(irq));
  icfm_video_src u_icfm_video_src (.raw_en(raw_en), .pll_en(pll_en), .raw(raw), .pll(pll));

  // Clock of 50 ns.
  always #25 clk = ~clk;

  // Count reset pulses so tests can compare how many were issued.
  always @(posedge clk) begin
    if (phy === 1'b1) phy_cnt <= phy_cnt + 8'h01;
    if (pllr === 1'b1) pll_cnt <= pll_cnt + 8'h01;
  end

  task chk8(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
    end
  endtask

  task chk1(input got, input exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t level %b expected %b", $time, got, exp);
      end
    end
  endtask

  // One classic cycle; the request is held until acknowledge is seen at an edge.
  task bus(input w, input [7:0] idx, input [7:0] d);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hf;
      wdat <= {24'h000000, d};
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (ack !== 1'b1 && n < 20);
      v = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) chk1(1'b0, 1'b1);
    end
  endtask

  task wr(input [7:0] idx, input [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task rd(input [7:0] idx, input [7:0] exp);
    begin
      bus(1'b0, idx, 8'h00);
      chk8(v, exp);
    end
  endtask

  task wait_us(input integer n);
    repeat (n * 20) @(posedge clk);
  endtask

  // Stability time of each code in microseconds; codes 2 and 3 use the shortened values.
  function integer stab_us(input [1:0] code);
    begin
      case (code)
        2'b00: stab_us = 40;
        2'b01: stab_us = 80;
        2'b10: stab_us = 8;
        default: stab_us = 16;
      endcase
    end
  endfunction

  task done(input [8*8-1:0] s);
    $display("Done: %0s", s);
  endtask

  task close_out;
    begin
      $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // A hang ends the run through the same closing task.
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    $display("BAD %0t watchdog expired", $time);
    close_out;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h5b, 8'h20);
    rd(8'h5c, 8'h02);
    rd(8'h5d, 8'h06);
    rd(8'h5e, 8'h2c);
    wr(8'h5e, 8'hff);
    rd(8'h5e, 8'h7f);
    wr(8'h5e, 8'h2c);
    wr(8'h5f, 8'hff);
    rd(8'h5f, 8'h00);
    rd(8'h10, 8'h00);
    done("reset");
    swap <= 1'b1;
    wait_us(1);
    chk1(sw_act, 1'b1);
    wr(8'h5b, 8'h20);
    chk1(sw_act, 1'b1);
    wr(8'h5c, 8'h82);
    wr(8'h5b, 8'h20);
    chk1(sw_act, 1'b0);
    rd(8'h5b, 8'h20);
    swap <= 1'b0;
    done("swap");
    wr(8'h5c, 8'h62);
    repeat (2) @(posedge clk);
    chk1(ready, 1'b1);
    chk1(valid, 1'b1);
    link <= 1'b1;
    wr(8'h5c, 8'h02);
    repeat (2) @(posedge clk);
    chk1(ready, 1'b1);
    chk1(valid, 1'b0);
    link <= 1'b0;
    done("force");
    // The 2.5 MHz source sits below the reset low limit, so the limit is lowered.
    wr(8'h5d, 8'h01);
    raw_en <= 1'b1;
    wait_us(4);
    bus(1'b0, 8'h5f, 8'h00);
    chk1(v >= 8'h01 && v <= 8'h03, 1'b1);
    hc = phy_cnt;
    pc = pll_cnt;
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h5c, {3'b000, i[1:0], 3'b010});
      wr(8'h5b, 8'h30);
      wait_us(3);
      rd(8'h5f, 8'h00);
      chk1(valid, 1'b0);
      wr(8'h5b, 8'h20);
      wait_us(stab_us(i[1:0]) - 3);
      chk1(valid, 1'b0);
      wait_us(7);
      chk1(valid, 1'b1);
    end
    chk8(pll_cnt - pc, 8'h08);
    chk8(phy_cnt - hc, 8'h08);
    done("stable");
    wr(8'h5d, 8'h04);
    repeat (2) @(posedge clk);
    chk1(valid, 1'b0);
    wr(8'h5d, 8'h01);
    wr(8'h5e, 8'h00);
    repeat (2) @(posedge clk);
    chk1(valid, 1'b0);
    wr(8'h5e, 8'h2c);
    repeat (2) @(posedge clk);
    chk1(valid, 1'b1);
    rd(8'h72, 8'h01);
    done("limits");
    rd(8'h70, 8'h07);
    chk1(irq, 1'b0);
    wr(8'h71, 8'h02);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b1);
    wr(8'h70, 8'h02);
    repeat (2) @(posedge clk);
    chk1(irq, 1'b0);
    rd(8'h70, 8'h05);
    done("irq");
    // With the 5 V detect high, mode bit 1 must suppress the receiver reset.
    s5v <= 1'b1;
    wr(8'h5d, 8'h41);
    hc = phy_cnt;
    mode <= ~mode;
    wait_us(1);
    chk8(phy_cnt, hc);
    wr(8'h5d, 8'h01);
    mode <= ~mode;
    wait_us(1);
    chk8(phy_cnt, hc + 8'h01);
    // Mode bit 1 without the 5 V detect must still reset the receiver.
    s5v <= 1'b0;
    wr(8'h5d, 8'h41);
    hc = phy_cnt;
    mode <= ~mode;
    wait_us(1);
    chk8(phy_cnt, hc + 8'h01);
    done("mode");
    // With the PLL reset bit off and the receiver reset held off, source changes pulse neither.
    s5v <= 1'b1;
    wait_us(1);
    hc = phy_cnt;
    pc = pll_cnt;
    wr(8'h5b, 8'h10);
    wait_us(3);
    rd(8'h5f, 8'h00);
    pll_en <= 1'b1;
    wait_us(3);
    bus(1'b0, 8'h5f, 8'h00);
    chk1(v >= 8'h01 && v <= 8'h03, 1'b1);
    chk8(pll_cnt, pc);
    chk8(phy_cnt, hc);
    done("source");
    close_out;
  end
endmodule

bind icfm_top icfm_props #(.STBL2_US(STBL2_US), .STBL3_US(STBL3_US)) u_icfm_props (
  .CLK(CLK), .RESET_N(RESET_N), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .LINK_DETECT(LINK_DETECT), .LINK_READY(LINK_READY),
  .SWAP_DETECTED(SWAP_DETECTED), .SWAP_ACTIVE(SWAP_ACTIVE), .PHY_RESET(PHY_RESET),
  .PLL_RESET(PLL_RESET));
